// ===== design/xmbs_mover.sv
`timescale 1ns/10ps
`default_nettype none
module xmbs_mover (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Job
	input wire logic start,
	input wire logic [12:0] count,
	// Step handshakes
	output logic stepRead,
	output logic stepWrite,
	output logic [12:0] index,
	output logic done
);
	xmbs_pkg::xmbs_xstate_t state;
	xmbs_pkg::xmbs_xstate_t next_state;
	logic [12:0] remain;
	wire logic lastWord;
	assign lastWord = (remain == 13'h0001);

	always_comb begin
		next_state = state;
		unique case (state)
			xmbs_pkg::XS_IDLE: if (start) next_state = xmbs_pkg::XS_READ;
			xmbs_pkg::XS_READ: next_state = xmbs_pkg::XS_WRITE;
			xmbs_pkg::XS_WRITE: next_state = lastWord ? xmbs_pkg::XS_DONE : xmbs_pkg::XS_READ;
			xmbs_pkg::XS_DONE: next_state = xmbs_pkg::XS_IDLE;
			default: next_state = xmbs_pkg::XS_IDLE;
		endcase
	end

	assign stepRead = (state == xmbs_pkg::XS_READ);
	assign stepWrite = (state == xmbs_pkg::XS_WRITE);
	assign done = (state == xmbs_pkg::XS_DONE);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= xmbs_pkg::XS_IDLE;
			remain <= 13'h0000;
			index <= 13'h0000;
		end else begin
			state <= next_state;
			if (state == xmbs_pkg::XS_IDLE && start) begin
				remain <= count;
				index <= 13'h0000;
			end else if (stepWrite) begin
				remain <= remain - 13'h0001;
				index <= index + 13'h0001;
			end
		end
	end
endmodule : xmbs_mover
`default_nettype wire

// ===== design/xmbs_pkg.sv
package xmbs_pkg;
	// Bank geometry
	localparam int BANK_WORDS = 6144;
	localparam logic [12:0] LAST_WORD = 13'h17ff;
	localparam int BANK_W = 4;
	localparam int WORD_W = 13;
	localparam int DATA_W = 16;
	localparam int RDM_W = 13;
	// Configuration codes and bank counts
	localparam logic [1:0] CFG_ONE = 2'h0;
	localparam logic [1:0] CFG_THREE = 2'h1;
	localparam logic [1:0] CFG_EIGHT = 2'h2;
	localparam logic [1:0] CFG_SIXTEEN = 2'h3;
	localparam logic [4:0] COUNT_ONE = 5'h01;
	localparam logic [4:0] COUNT_THREE = 5'h03;
	localparam logic [4:0] COUNT_EIGHT = 5'h08;
	localparam logic [4:0] COUNT_SIXTEEN = 5'h10;
	// Reset values
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [8:0] IND_REGULAR = 9'h000;
	// Command codes
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_BANK_CHANGE = 3'h1;
	localparam logic [2:0] CMD_CUR_XFER = 3'h2;
	localparam logic [2:0] CMD_EXP_XFER = 3'h3;
	localparam logic [2:0] CMD_INDIRECT_DEST = 3'h4;

	typedef enum logic [3:0] {
		XS_IDLE = 4'b0001,
		XS_READ = 4'b0010,
		XS_WRITE = 4'b0100,
		XS_DONE = 4'b1000
	} xmbs_xstate_t;

	function automatic logic [4:0] xmbs_bank_count(input logic [1:0] cfg);
		unique case (cfg)
			CFG_ONE: xmbs_bank_count = COUNT_ONE;
			CFG_THREE: xmbs_bank_count = COUNT_THREE;
			CFG_EIGHT: xmbs_bank_count = COUNT_EIGHT;
			CFG_SIXTEEN: xmbs_bank_count = COUNT_SIXTEEN;
		endcase
	endfunction : xmbs_bank_count

	function automatic logic xmbs_bank_ok(input logic [3:0] bank, input logic [1:0] cfg);
		xmbs_bank_ok = ({1'b0, bank} < xmbs_bank_count(cfg));
	endfunction : xmbs_bank_ok
endpackage : xmbs_pkg

// ===== design/xmbs_selector.sv
`timescale 1ns/10ps
`default_nettype none
module xmbs_selector (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Events
	input wire logic scanStart,
	input wire logic intEnter,
	input wire logic intReturn,
	input wire logic bankLoad,
	input wire logic [3:0] bankValue,
	input wire logic indLoad,
	input wire logic indExtended,
	// State
	output logic [3:0] currentBank,
	output logic indRedirect,
	output logic [3:0] indBank
);
	logic savedRedirect;
	logic [3:0] savedBank;
	wire logic indGoRegular;
	assign indGoRegular = scanStart | intEnter;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			currentBank <= xmbs_pkg::BANK_RESET;
		end else if (bankLoad) begin
			currentBank <= bankValue;
		end
	end
	// Current bank ignores scan start, interrupts and mode changes

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			indRedirect <= 1'b0;
			indBank <= xmbs_pkg::BANK_RESET;
			savedRedirect <= 1'b0;
			savedBank <= xmbs_pkg::BANK_RESET;
		end else if (intEnter) begin
			savedRedirect <= indRedirect;
			savedBank <= indBank;
			indRedirect <= 1'b0;
		end else if (intReturn) begin
			indRedirect <= savedRedirect;
			indBank <= savedBank;
		end else if (indGoRegular) begin
			indRedirect <= 1'b0;
		end else if (indLoad) begin
			indRedirect <= indExtended;
			indBank <= bankValue;
		end
	end
endmodule : xmbs_selector
`default_nettype wire

// ===== design/xmbs_top.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Each bank holds 6,144 words, addressed 0 to 6143.
// - The configuration sets one, three, eight or sixteen implemented banks.
// - Plain operands reach only the current bank; other banks need bank commands.
// - The bank-change command loads the current bank from its operand.
// - The current-bank transfer copies words inside the current bank or to and from regular memory, bank unchanged.
// - The explicit-bank transfer copies words between a named bank and another bank or regular memory.
// - The indirect-destination command routes pointer accesses to a bank, or back to regular memory for 000.
// - While redirected, a pointer's content is the word address inside the chosen bank.
// - Each scan start returns the indirect destination to regular memory, except in a cycle with interrupt return, which restores it instead.
// - Interrupt entry saves the indirect destination and clears it; return restores it.
// - Power-on sets the current bank to 0.
// - Both the bank-change and the indirect-destination commands can update the current bank.
// - Scan start and interrupt entry leave the current bank alone.
// - The current bank survives mode changes and interrupt completion.
module xmbs_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Configuration and sequencing
	input wire logic [1:0] bankConfig,
	input wire logic scanStart,
	input wire logic intEnter,
	input wire logic intReturn,
	// Command port
	input wire logic cmdValid,
	input wire logic [2:0] cmdCode,
	input wire logic [8:0] cmdBank,
	input wire logic [3:0] cmdDstBank,
	input wire logic cmdSrcRegular,
	input wire logic cmdDstRegular,
	input wire logic [12:0] cmdSrcAddr,
	input wire logic [12:0] cmdDstAddr,
	input wire logic [12:0] cmdCount,
	output logic cmdBusy,
	output logic cmdDone,
	output logic cmdError,
	// Operand access
	input wire logic opValid,
	input wire logic opWrite,
	input wire logic opIndirect,
	input wire logic [12:0] opAddr,
	input wire logic [15:0] opWdata,
	output logic [15:0] opRdata,
	output logic opError,
	// Regular data memory port
	output logic rdmWrite,
	output logic rdmRead,
	output logic [12:0] rdmAddr,
	output logic [15:0] rdmWdata,
	input wire logic [15:0] rdmRdata,
	// Selector state
	output logic [3:0] currentBank,
	output logic indRedirect,
	output logic [3:0] indBank
);
	localparam int NWORDS = xmbs_pkg::BANK_WORDS * int'(xmbs_pkg::COUNT_SIXTEEN);
	logic [15:0] mem [0:NWORDS-1];
	logic [3:0] curBankQ;
	logic redirQ;
	logic [3:0] indBankQ;
	logic [3:0] srcBankR;
	logic [3:0] dstBankR;
	logic srcRegR;
	logic dstRegR;
	logic [12:0] srcAddrR;
	logic [12:0] dstAddrR;
	logic [15:0] holdData;
	logic jobActive;
	wire logic [3:0] opBankN;
	wire logic [3:0] srcBankN;
	wire logic bankInRange;
	wire logic [8:0] bankLimit;
	wire logic [8:0] bankOperand;
	wire logic dstInRange;
	wire logic indExtended;
	wire logic isBankChange;
	wire logic isIndirect;
	wire logic isCurXfer;
	wire logic isExpXfer;
	wire logic cmdOk;
	wire logic cmdBad;
	wire logic bankLoad;
	wire logic indLoad;
	wire logic xferStart;
	wire logic stepRead;
	wire logic stepWrite;
	wire logic moverDone;
	wire logic [12:0] moveIdx;
	wire logic [12:0] srcWord;
	wire logic [12:0] dstWord;
	wire logic opToRdm;
	wire logic [3:0] opBank;
	wire logic opRange;
	wire logic [16:0] opIndex;
	wire logic [16:0] srcIndex;
	wire logic [16:0] dstIndex;
	wire logic xferRange;

	function automatic logic [16:0] flatIndex(input logic [3:0] bank, input logic [12:0] word);
		flatIndex = 17'(bank) * 17'(xmbs_pkg::BANK_WORDS) + 17'(word);
	endfunction : flatIndex

	function automatic logic wordOk(input logic [12:0] word);
		wordOk = (word <= xmbs_pkg::LAST_WORD);
	endfunction : wordOk

	// Command decode
	assign isBankChange = cmdCode == xmbs_pkg::CMD_BANK_CHANGE;
	assign isIndirect = cmdCode == xmbs_pkg::CMD_INDIRECT_DEST;
	assign isCurXfer = cmdCode == xmbs_pkg::CMD_CUR_XFER;
	assign isExpXfer = cmdCode == xmbs_pkg::CMD_EXP_XFER;
	assign indExtended = cmdBank != xmbs_pkg::IND_REGULAR;
	assign opBankN = indExtended ? cmdBank[3:0] - 4'h1 : 4'h0;
	assign bankLimit = {4'h0, xmbs_pkg::xmbs_bank_count(bankConfig)};
	assign bankOperand = isIndirect ? cmdBank - 9'h001 : cmdBank;
	assign bankInRange = bankOperand < bankLimit;
	assign dstInRange = cmdDstRegular || xmbs_pkg::xmbs_bank_ok(cmdDstBank, bankConfig);
	assign srcBankN = isCurXfer ? curBankQ : cmdBank[3:0];
	assign xferRange = wordOk(cmdSrcAddr) && wordOk(cmdDstAddr)
		&& ({1'b0, cmdSrcAddr} + {1'b0, cmdCount} <= 14'(xmbs_pkg::BANK_WORDS))
		&& ({1'b0, cmdDstAddr} + {1'b0, cmdCount} <= 14'(xmbs_pkg::BANK_WORDS));
	assign cmdOk = cmdValid && !jobActive && (
		isBankChange ? bankInRange :
		isIndirect ? (!indExtended || bankInRange) :
		isCurXfer ? (xferRange && (cmdCount != 13'h0000)) :
		isExpXfer ? (bankInRange && dstInRange && xferRange && (cmdCount != 13'h0000)) : 1'b0);
	assign cmdBad = cmdValid && !jobActive && !cmdOk && (cmdCode != xmbs_pkg::CMD_NONE);
	assign bankLoad = cmdOk && (isBankChange || (isIndirect && indExtended));
	assign indLoad = cmdOk && isIndirect;
	assign xferStart = cmdOk && (isCurXfer || isExpXfer);

	xmbs_selector u_selector (
		.mclk(mclk),
		.rst_n(rst_n),
		.scanStart(scanStart),
		.intEnter(intEnter),
		.intReturn(intReturn),
		.bankLoad(bankLoad),
		.bankValue(isIndirect ? opBankN : cmdBank[3:0]),
		.indLoad(indLoad),
		.indExtended(indExtended),
		.currentBank(curBankQ),
		.indRedirect(redirQ),
		.indBank(indBankQ)
	);

	xmbs_mover u_mover (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(xferStart),
		.count(cmdCount),
		.stepRead(stepRead),
		.stepWrite(stepWrite),
		.index(moveIdx),
		.done(moverDone)
	);

	// Operand routing
	assign opToRdm = opIndirect && !redirQ;
	assign opBank = opIndirect ? indBankQ : curBankQ;
	assign opRange = wordOk(opAddr);
	assign opIndex = flatIndex(opBank, opAddr);
	assign srcWord = srcAddrR + moveIdx;
	assign dstWord = dstAddrR + moveIdx;
	assign srcIndex = flatIndex(srcBankR, srcWord);
	assign dstIndex = flatIndex(dstBankR, dstWord);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			jobActive <= 1'b0;
			srcBankR <= xmbs_pkg::BANK_RESET;
			dstBankR <= xmbs_pkg::BANK_RESET;
			srcRegR <= 1'b0;
			dstRegR <= 1'b0;
			srcAddrR <= 13'h0000;
			dstAddrR <= 13'h0000;
		end else if (xferStart) begin
			jobActive <= 1'b1;
			srcBankR <= srcBankN;
			dstBankR <= isCurXfer ? curBankQ : cmdDstBank;
			srcRegR <= cmdSrcRegular;
			dstRegR <= cmdDstRegular;
			srcAddrR <= cmdSrcAddr;
			dstAddrR <= cmdDstAddr;
		end else if (moverDone) begin
			jobActive <= 1'b0;
		end
	end

	// Bank storage and word moves
	always_ff @(posedge mclk) begin
		if (stepRead) begin
			holdData <= srcRegR ? rdmRdata : mem[srcIndex];
		end
		if (stepWrite && !dstRegR) begin
			mem[dstIndex] <= srcRegR ? rdmRdata : holdData;
		end else if (opValid && opWrite && !jobActive && !opToRdm && opRange) begin
			mem[opIndex] <= opWdata;
		end
	end

	// Outputs, all registered
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmdBusy <= 1'b0;
			cmdDone <= 1'b0;
			cmdError <= 1'b0;
			opRdata <= 16'h0000;
			opError <= 1'b0;
			rdmWrite <= 1'b0;
			rdmRead <= 1'b0;
			rdmAddr <= 13'h0000;
			rdmWdata <= 16'h0000;
			currentBank <= xmbs_pkg::BANK_RESET;
			indRedirect <= 1'b0;
			indBank <= xmbs_pkg::BANK_RESET;
		end else begin
			cmdBusy <= xferStart || (jobActive && !moverDone);
			cmdDone <= moverDone || (cmdOk && !xferStart);
			cmdError <= cmdBad;
			opError <= opValid && !jobActive && !opToRdm && !opRange;
			opRdata <= (opValid && !opWrite && !opToRdm && opRange) ? mem[opIndex] : 16'h0000;
			rdmRead <= (opValid && !opWrite && opToRdm) || (xferStart && cmdSrcRegular)
				|| (stepWrite && srcRegR && !moverDone);
			rdmWrite <= (opValid && opWrite && opToRdm && !jobActive) || (stepRead && dstRegR);
			rdmAddr <= (stepRead && dstRegR) ? dstWord :
				(xferStart ? cmdSrcAddr : (stepWrite ? srcWord + 13'h0001 : opAddr));
			rdmWdata <= (stepRead && dstRegR) ? mem[srcIndex] : opWdata;
			currentBank <= curBankQ;
			indRedirect <= redirQ;
			indBank <= indBankQ;
		end
	end
endmodule : xmbs_top
`default_nettype wire

// ===== sim/test_extended_memory_bank_select.sv
`timescale 1ns/10ps
`default_nettype none
module test_extended_memory_bank_select;
	localparam logic [2:0] CHG = xmbs_pkg::CMD_BANK_CHANGE;
	localparam logic [2:0] IND = xmbs_pkg::CMD_INDIRECT_DEST;
	localparam logic [2:0] CUR = xmbs_pkg::CMD_CUR_XFER;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] bankConfig = 2'h3;
	logic scanStart = 1'b0, intEnter = 1'b0, intReturn = 1'b0, cmdValid = 1'b0;
	logic [2:0] cmdCode = 3'h0;
	logic [8:0] cmdBank = 9'h000;
	logic [3:0] cmdDstBank = 4'h0;
	logic cmdSrcRegular = 1'b0, cmdDstRegular = 1'b0, opValid = 1'b0, opWrite = 1'b0, opIndirect = 1'b0;
	logic [12:0] cmdSrcAddr = 13'h0000, cmdDstAddr = 13'h0000, cmdCount = 13'h0000, opAddr = 13'h0000;
	logic [15:0] opWdata = 16'h0000;
	wire logic [15:0] rdmRdata, opRdata, rdmWdata;
	wire logic cmdBusy, cmdDone, cmdError, opError, rdmWrite, rdmRead, indRedirect;
	wire logic [12:0] rdmAddr;
	wire logic [3:0] currentBank, indBank;
	logic [15:0] rdm [8192];
	logic [9:0] notes [$];
	logic [15:0] reads [$];
	logic [31:0] seed = 32'hf8ef;
	logic [3:0] expBank = 4'h0, expInd = 4'h0, saveInd;
	logic expRedir = 1'b0, saveRedir;
	int lims [4] = '{1, 3, 8, 16};
	int failures = 0, compares = 0;
	logic [12:0] a, b;
	logic [15:0] v;
	xmbs_top i_xmbs_top (.*);
	assign rdmRdata = rdm[rdmAddr];
	always @(posedge mclk) if (rdmWrite === 1'b1) rdm[rdmAddr] <= rdmWdata;
	always #2 mclk = ~mclk;
	function automatic int rnd(input int m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed % m;
	endfunction : rnd
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic conclude();
		if (failures == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask : pulse
	task automatic see();
		check({7'h00, currentBank, indRedirect, indRedirect ? indBank : 4'h0},
			{7'h00, expBank, expRedir, expRedir ? expInd : 4'h0});
	endtask : see
	task automatic command(input logic [2:0] code, input logic [8:0] bank, input logic [12:0] n = 13'h0001,
			input logic [3:0] dst = 4'h0, input logic [12:0] sa = 13'h0000, input logic [12:0] da = 13'h0000);
		logic bad;
		int i;
		bad = code == IND ? bank > lims[bankConfig] : (code != CUR && bank >= lims[bankConfig]) || n == 13'h0000;
		if (!bad && code == CHG) expBank = bank[3:0];
		if (!bad && code == IND) begin
			expRedir = bank != 9'h000;
			if (expRedir) expBank = bank[3:0] - 4'h1;
			if (expRedir) expInd = expBank;
		end
		step(1);
		cmdValid = 1'b1;
		cmdCode = code;
		cmdBank = bank;
		cmdCount = n;
		cmdDstBank = dst;
		cmdSrcAddr = sa;
		cmdDstAddr = da;
		notes.push_back({bad, expBank, expRedir, expRedir ? expInd : 4'h0});
		step(1);
		cmdValid = 1'b0;
		for (i = 0; i < 100 && cmdDone !== 1'b1 && cmdError !== 1'b1; i++) step(1);
		if (i == 100) begin
			failures++;
			conclude();
		end
	endtask : command
	task automatic operand(input logic wr, input logic [12:0] ad, input logic [15:0] d, input logic ind = 1'b0);
		step(1);
		opValid = 1'b1;
		opWrite = wr;
		opIndirect = ind;
		opAddr = ad;
		opWdata = d;
		if (!wr && (!ind || expRedir)) reads.push_back(d);
		step(1);
		opValid = 1'b0;
	endtask : operand
	initial begin : observe
		logic rd, pend, er, rr;
		logic [12:0] ra;
		logic [9:0] n;
		pend = 1'b0;
		forever begin
			@(posedge mclk);
			rr = opValid && !opWrite && opIndirect && !expRedir && !cmdBusy;
			rd = opValid && !opWrite && !cmdBusy && !(opIndirect && !expRedir);
			er = opValid && !cmdBusy && !(opIndirect && !expRedir) && opAddr > xmbs_pkg::LAST_WORD;
			ra = opAddr;
			#2;
			if (rd) check(opRdata, reads.pop_front());
			check({15'h0000, opError}, {15'h0000, er});
			check({15'h0000, rdmRead}, {15'h0000, rr});
			if (rr) check({3'h0, rdmAddr}, {3'h0, ra});
			if (pend) check({7'h00, currentBank, indRedirect, indRedirect ? indBank : 4'h0}, {7'h00, n[8:0]});
			pend = cmdDone === 1'b1 || cmdError === 1'b1;
			if (pend) n = notes.size() > 0 ? notes.pop_front() : 10'h3ff;
			if (pend) check({15'h0000, cmdError}, {15'h0000, n[9]});
		end
	end
	initial begin
		step(10);
		rst_n = 1'b1;
		see();
		for (int c = 0; c < 4; c++) begin
			bankConfig = c[1:0];
			command(CHG, 9'(lims[c] - 1));
			command(CHG, 9'(lims[c]));
			command(IND, 9'(lims[c] + 1));
			command(IND, 9'(lims[c]));
			command(IND, 9'h000);
		end
		repeat (6) command(CHG, 9'(rnd(16)));
		a = 13'(rnd(6140));
		b = 13'(rnd(6140));
		v = 16'(rnd(65536));
		command(CHG, 9'h001);
		operand(1'b1, a, v);
		command(CHG, 9'h002);
		operand(1'b1, a, ~v);
		operand(1'b0, a, ~v);
		command(CHG, 9'h001);
		operand(1'b0, a, v);
		command(xmbs_pkg::CMD_EXP_XFER, 9'h001, 13'h0001, 4'h5, a, b);
		command(CHG, 9'h005);
		operand(1'b0, b, v);
		command(CUR, 9'h000, 13'h0001, 4'h0, b, 13'h17ff);
		operand(1'b0, 13'h17ff, v);
		command(CUR, 9'h000, 13'h0000);
		operand(1'b1, 13'h1800, v);
		operand(1'b1, b, ~v, 1'b1);
		step(1);
		check(rdm[b], ~v);
		operand(1'b0, b, v);
		operand(1'b0, b, 16'h0000, 1'b1);
		command(IND, 9'h004);
		operand(1'b1, a, ~v, 1'b1);
		operand(1'b0, a, ~v);
		operand(1'b0, a, ~v, 1'b1);
		pulse(scanStart);
		expRedir = 1'b0;
		step(3);
		see();
		command(IND, 9'h007);
		pulse(intEnter);
		saveRedir = expRedir;
		saveInd = expInd;
		expRedir = 1'b0;
		step(3);
		see();
		command(IND, 9'h003);
		pulse(intReturn);
		expRedir = saveRedir;
		expInd = saveInd;
		step(3);
		see();
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		expBank = 4'h0;
		expRedir = 1'b0;
		see();
		step(2);
		conclude();
	end
endmodule : test_extended_memory_bank_select
`default_nettype wire

// ===== sim/xmbs_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module xmbs_top_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Watched inputs
	input wire logic [1:0] bankConfig,
	input wire logic scanStart,
	input wire logic intEnter,
	input wire logic intReturn,
	input wire logic cmdValid,
	input wire logic [2:0] cmdCode,
	input wire logic [8:0] cmdBank,
	input wire logic opValid,
	input wire logic [12:0] opAddr,
	// Watched outputs
	input wire logic cmdBusy,
	input wire logic cmdDone,
	input wire logic cmdError,
	input wire logic opError,
	input wire logic [3:0] currentBank,
	input wire logic indRedirect,
	input wire logic [3:0] indBank
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic [8:0] limit = {4'h0, xmbs_pkg::xmbs_bank_count(bankConfig)};
	wire logic take = cmdValid && !cmdBusy && !scanStart && !intEnter && !intReturn;
	wire logic change = take && cmdCode == xmbs_pkg::CMD_BANK_CHANGE;
	wire logic route = take && cmdCode == xmbs_pkg::CMD_INDIRECT_DEST;
	a_bank_change_load: assert property (change && cmdBank < limit |->
		##1 cmdDone ##1 currentBank == $past(cmdBank[3:0], 2)) else $error("bank change lost");
	a_bad_bank_kept: assert property (change && cmdBank >= limit |->
		##1 cmdError && !cmdDone ##1 $stable(currentBank)) else $error("bad bank taken");
	a_route_bank: assert property (route && cmdBank != 9'h000 && cmdBank <= limit |->
		##2 indRedirect && indBank == $past(cmdBank[3:0], 2) - 4'h1 && currentBank == indBank)
		else $error("indirect bank wrong");
	a_route_regular: assert property (route && cmdBank == 9'h000 |-> ##2 !indRedirect)
		else $error("indirect not regular");
	a_scan_clears: assert property (scanStart && !intEnter && !intReturn |-> ##2 !indRedirect)
		else $error("scan kept redirect");
	a_entry_clears: assert property (intEnter |-> ##2 !indRedirect)
		else $error("entry kept redirect");
	a_bank_kept: assert property ((scanStart || intEnter || intReturn) && !cmdValid |-> ##2 $stable(currentBank))
		else $error("bank moved on event");
	a_xfer_holds: assert property (cmdBusy && $past(cmdBusy) |-> $stable(currentBank) && $stable(indRedirect))
		else $error("selector moved in transfer");
	a_op_range: assert property (opValid && !cmdBusy |=> opError == ($past(opAddr) > xmbs_pkg::LAST_WORD))
		else $error("operand range flag wrong");
	a_reset_bank: assert property (disable iff (1'b0) !rst_n |=> currentBank == xmbs_pkg::BANK_RESET && !indRedirect)
		else $error("reset state wrong");
	c_change: cover property (change ##1 cmdDone);
	c_refuse: cover property (cmdError);
	c_xfer: cover property (cmdBusy ##1 cmdDone);
endmodule : xmbs_top_sva
bind xmbs_top xmbs_top_sva i_xmbs_top_sva (.*);
`default_nettype wire
